// file: verilog/msrs_pkg.sv
// Package: constants for the transfer-service request selector
package msrs_pkg;

    // ****************************************
    // Source count and widths
    // ****************************************
    localparam int MSRS_NUM_SRC = 23;
    localparam int MSRS_RANK_W = 5;
    localparam int MSRS_ADDR_W = 16;
    localparam int MSRS_KIND_W = 2;

    // ****************************************
    // Control word addresses, indexed by rank
    // ****************************************
    localparam logic [15:0] MSRS_CW_ADDR [0:22] = '{
        16'hFE06, 16'hFE08, 16'hFE0A, 16'hFE0C,
        16'hFE0E, 16'hFE10,
        16'hFE12, 16'hFE14,
        16'hFE16, 16'hFE18,
        16'hFE1A,
        16'hFE1C, 16'hFE1E,
        16'hFE20,
        16'hFE24, 16'hFE26,
        16'hFE28,
        16'hFE2C, 16'hFE2E,
        16'hFE32, 16'hFE34,
        16'hFE36,
        16'hFE38
    };

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] MSRS_ADDR_RST = 16'h0000;
    localparam logic [4:0] MSRS_RANK_RST = 5'h00;

    // ****************************************
    // Transfer-service kinds
    // ****************************************
    typedef enum logic [1:0] {
        MSRS_KIND_A = 2'h0,
        MSRS_KIND_B = 2'h1,
        MSRS_KIND_C = 2'h2,
        MSRS_KIND_CNT = 2'h3
    } msrs_kind_t;

    // ****************************************
    // Selector states (Gray along the path)
    // ****************************************
    typedef enum logic [1:0] {
        MSRS_IDLE = 2'h0,
        MSRS_GRANT = 2'h1,
        MSRS_WAIT = 2'h3
    } msrs_state_t;

endpackage

// file: verilog/msrs_select.sv
// Module: fixed-rank transfer-service request selector
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Twenty-three request sources, each with own rank and control word.
// - Each source carries one of four transfer kinds, set per source.
// - Fixed rank alone orders simultaneous requests.
// - Pin edges 0-3 are ranks 0-3 at FE06, FE08, FE0A, FE0C.
// - Timer 0 matches are ranks 4, 5 at FE0E, FE10.
// - Timer 1 matches, either width, ranks 6, 7 at FE12, FE14.
// - Timer 2 matches, either width, ranks 8, 9 at FE16, FE18.
// - Timer 3 match, either width, rank 10 at FE1A.
// - Pin edges 4, 5 are ranks 11, 12 at FE1C, FE1E.
// - Conversion done is rank 13 at FE20.
// - Serial 1 receive/clocked end rank 14 FE24; transmit end rank 15 FE26.
// - Dedicated clocked serial end is rank 16 at FE28.
// - Serial 2 receive/clocked end rank 17 FE2C; transmit end rank 18 FE2E.
// - Network bus access rank 19 FE32; error or end rank 20 FE34.
// - Watch timer output is rank 21 at FE36.
// - Clocked serial 3 end is rank 22 at FE38.
// - Any unmasked, enabled pending transfer request goes before vectored interrupts.
// - Global enable and in-service priority do not block transfer requests.
// - A source with its mask flag set stays pending and is not granted until the flag clears.
module msrs_select (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Pin edge sources
    input wire logic pin_edge_req_0,
    input wire logic pin_edge_req_1,
    input wire logic pin_edge_req_2,
    input wire logic pin_edge_req_3,
    input wire logic pin_edge_req_4,
    input wire logic pin_edge_req_5,
    // Timer sources; wide and narrow compares are merged by the timers
    input wire logic tmr0_match_a_req,
    input wire logic tmr0_match_b_req,
    input wire logic tmr1_match_a_req,
    input wire logic tmr1_match_b_req,
    input wire logic tmr2_match_a_req,
    input wire logic tmr2_match_b_req,
    input wire logic tmr3_match_req,
    // Converter, serial, network and watch sources
    input wire logic adc_done_req,
    input wire logic uart1_rx_done_req,
    input wire logic sio1_xfer_done_req,
    input wire logic uart1_tx_done_req,
    input wire logic sio0_xfer_done_req,
    input wire logic uart2_rx_done_req,
    input wire logic sio2_xfer_done_req,
    input wire logic uart2_tx_done_req,
    input wire logic netbus_access_req,
    input wire logic netbus_err_end_req,
    input wire logic watch_tick_req,
    input wire logic sio3_xfer_done_req,
    // Per-source configuration, bit index is rank; service_kind takes two bits per rank at 2*rank
    input wire logic [msrs_pkg::MSRS_NUM_SRC-1:0] source_mask_flags,
    input wire logic [msrs_pkg::MSRS_NUM_SRC-1:0] service_enable,
    input wire logic [2*msrs_pkg::MSRS_NUM_SRC-1:0] service_kind,
    // Sequencer handshake
    input wire logic seq_done,
    // Grant to sequencer
    output logic grant_valid,
    output logic [msrs_pkg::MSRS_RANK_W-1:0] grant_rank,
    output logic [msrs_pkg::MSRS_ADDR_W-1:0] grant_cw_addr,
    output logic [msrs_pkg::MSRS_KIND_W-1:0] grant_kind,
    output logic vector_hold,
    output logic [msrs_pkg::MSRS_NUM_SRC-1:0] pending_flags
);
    import msrs_pkg::*;

    // ****************************************
    // Request gathering
    // ****************************************
    logic [MSRS_NUM_SRC-1:0] raw_req;
    logic [MSRS_NUM_SRC-1:0] pend_reg;
    logic [MSRS_NUM_SRC-1:0] pend_next;
    logic [MSRS_NUM_SRC-1:0] clr_vec;
    logic [MSRS_NUM_SRC-1:0] elig;
    logic any_elig;
    logic [MSRS_RANK_W-1:0] win_rank;
    msrs_state_t state_reg;

    // One line per rank; serial roles share one source and are ORed
    always_comb begin
        raw_req[0] = pin_edge_req_0;
        raw_req[1] = pin_edge_req_1;
        raw_req[2] = pin_edge_req_2;
        raw_req[3] = pin_edge_req_3;
        raw_req[4] = tmr0_match_a_req;
        raw_req[5] = tmr0_match_b_req;
        raw_req[6] = tmr1_match_a_req;
        raw_req[7] = tmr1_match_b_req;
        raw_req[8] = tmr2_match_a_req;
        raw_req[9] = tmr2_match_b_req;
        raw_req[10] = tmr3_match_req;
        raw_req[11] = pin_edge_req_4;
        raw_req[12] = pin_edge_req_5;
        raw_req[13] = adc_done_req;
        raw_req[14] = uart1_rx_done_req | sio1_xfer_done_req;
        raw_req[15] = uart1_tx_done_req;
        raw_req[16] = sio0_xfer_done_req;
        raw_req[17] = uart2_rx_done_req | sio2_xfer_done_req;
        raw_req[18] = uart2_tx_done_req;
        raw_req[19] = netbus_access_req;
        raw_req[20] = netbus_err_end_req;
        raw_req[21] = watch_tick_req;
        raw_req[22] = sio3_xfer_done_req;
    end

    // ****************************************
    // Pending flags
    // ****************************************
    // No global enable or level input exists here on purpose
    assign elig = pend_reg & ~source_mask_flags & service_enable;
    assign any_elig = |elig;

    // Lowest set index wins; scanned downward so the smallest rank lands last
    always_comb begin
        win_rank = MSRS_RANK_RST;
        for (int i = MSRS_NUM_SRC - 1; i >= 0; i--) begin
            if (elig[i]) begin
                win_rank = MSRS_RANK_W'(i);
            end
        end
    end

    always_comb begin
        clr_vec = '0;
        if (state_reg == MSRS_WAIT && seq_done) begin
            clr_vec[grant_rank] = 1'b1;
        end
    end

    // A new edge in the clearing cycle survives the clear
    assign pend_next = (pend_reg & ~clr_vec) | raw_req;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pending_flags <= '0;
        end else begin
            pending_flags <= pend_next;
        end
    end

    // ****************************************
    // Grant sequencing
    // ****************************************
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= MSRS_IDLE;
            grant_valid <= 1'b0;
            grant_rank <= MSRS_RANK_RST;
            grant_cw_addr <= MSRS_ADDR_RST;
            grant_kind <= 2'h0;
        end else begin
            case (state_reg)
                MSRS_IDLE: begin
                    if (any_elig) begin
                        state_reg <= MSRS_GRANT;
                        grant_valid <= 1'b1;
                        grant_rank <= win_rank;
                        grant_cw_addr <= MSRS_CW_ADDR[win_rank];
                        grant_kind <= service_kind[2*win_rank +: 2];
                    end
                end
                MSRS_GRANT: begin
                    state_reg <= MSRS_WAIT;
                end
                MSRS_WAIT: begin
                    if (seq_done) begin
                        state_reg <= MSRS_IDLE;
                        grant_valid <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= MSRS_IDLE;
                    grant_valid <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Vectored interrupt hold-off
    // ****************************************
    // Held while any eligible request waits or a grant is open
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            vector_hold <= 1'b0;
        end else begin
            vector_hold <= (|(pend_next & ~source_mask_flags & service_enable))
                | (state_reg != MSRS_IDLE && !(state_reg == MSRS_WAIT && seq_done));
        end
    end

endmodule
`default_nettype wire

// file: bench/msrs_monitor.sv
// Checker for the transfer-service request selector
`timescale 1ns/100ps
`default_nettype none
module msrs_monitor import msrs_pkg::*; (
    // Clock, reset and requests
    input wire logic mclk, rstn, seq_done, pin_edge_req_0,
    // Configuration
    input wire logic [22:0] source_mask_flags, service_enable,
    input wire logic [45:0] service_kind,
    // Grant side
    input wire logic grant_valid, vector_hold,
    input wire logic [22:0] pending_flags,
    input wire logic [4:0] grant_rank,
    input wire logic [1:0] grant_kind,
    input wire logic [15:0] grant_cw_addr
);
    logic [22:0] elig_reg;
    // Eligible set as the grant decision saw it, one edge back
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) elig_reg <= 23'h0;
        else elig_reg <= pending_flags & ~source_mask_flags & service_enable;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    rank_range_a: assert property (grant_valid |-> grant_rank < 5'h17)
        else $error("grant rank out of range");
    addr_map_a: assert property (grant_valid |-> grant_cw_addr == MSRS_CW_ADDR[grant_rank])
        else $error("control word address wrong");
    kind_a: assert property (grant_valid |-> grant_kind == service_kind[2*grant_rank+:2])
        else $error("grant kind wrong");
    pick_first_a: assert property ($rose(grant_valid) |-> elig_reg[grant_rank] &&
        (elig_reg & ((23'h1 << grant_rank) - 23'h1)) == 23'h0) else $error("wrong winner");
    hold_grant_a: assert property (grant_valid && !(seq_done && $past(grant_valid))
        |=> grant_valid && $stable(grant_rank)) else $error("grant dropped early");
    seq_end_a: assert property (grant_valid && $past(grant_valid) && seq_done |=> !grant_valid)
        else $error("grant not ended");
    vec_hold_a: assert property (grant_valid |-> vector_hold)
        else $error("vectored not held");
    pend_latch_a: assert property (pin_edge_req_0 |=> pending_flags[0])
        else $error("request not latched");
endmodule
bind msrs_select msrs_monitor msrs_monitor_i (.*);
`default_nettype wire

// file: bench/msrs_seq_model.sv
// Sequencer model that ends each grant after a set number of cycles
`timescale 1ns/100ps
`default_nettype none
module msrs_seq_model (
    input wire logic mclk, rstn, grant_valid,
    input wire logic [3:0] gap,
    output logic seq_done
);
    logic [3:0] cnt_reg;
    // Falling edge drive; gap 1 lands in the first grant cycle and is refused
    always_ff @(negedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 4'h0;
            seq_done <= 1'b0;
        end else if (grant_valid && !seq_done) begin
            cnt_reg <= cnt_reg + 4'h1;
            seq_done <= (cnt_reg + 4'h1) == gap;
        end else begin
            cnt_reg <= 4'h0;
            seq_done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: bench/test_macro_service_request_select.sv
// Testbench for the transfer-service request selector
`timescale 1ns/100ps
`default_nettype none
module test_macro_service_request_select;
    import msrs_pkg::*;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [22:0] r = 23'h0, mask = 23'h0, en = 23'h7FFFFF;
    logic [45:0] kind = 46'h0;
    logic [1:0] sx = 2'h0;
    logic [3:0] gap = 4'h3;
    logic seq_done, gv, vh;
    logic [4:0] rank;
    logic [15:0] addr;
    logic [1:0] gk;
    logic [22:0] pend;
    int fail_count = 0;
    int n_checks = 0;
    initial forever #2.5 mclk = ~mclk;
    msrs_select msrs_select_i (.mclk(mclk), .rstn(rstn),
        .pin_edge_req_0(r[0]), .pin_edge_req_1(r[1]), .pin_edge_req_2(r[2]),
        .pin_edge_req_3(r[3]), .pin_edge_req_4(r[11]), .pin_edge_req_5(r[12]),
        .tmr0_match_a_req(r[4]), .tmr0_match_b_req(r[5]), .tmr1_match_a_req(r[6]),
        .tmr1_match_b_req(r[7]), .tmr2_match_a_req(r[8]), .tmr2_match_b_req(r[9]),
        .tmr3_match_req(r[10]), .adc_done_req(r[13]), .uart1_rx_done_req(r[14]),
        .sio1_xfer_done_req(sx[0]), .uart1_tx_done_req(r[15]), .sio0_xfer_done_req(r[16]),
        .uart2_rx_done_req(r[17]), .sio2_xfer_done_req(sx[1]), .uart2_tx_done_req(r[18]),
        .netbus_access_req(r[19]), .netbus_err_end_req(r[20]), .watch_tick_req(r[21]),
        .sio3_xfer_done_req(r[22]), .source_mask_flags(mask), .service_enable(en),
        .service_kind(kind), .seq_done(seq_done), .grant_valid(gv), .grant_rank(rank),
        .grant_cw_addr(addr), .grant_kind(gk), .vector_hold(vh), .pending_flags(pend));
    msrs_seq_model msrs_seq_model_i (.mclk(mclk), .rstn(rstn), .grant_valid(gv),
        .gap(gap), .seq_done(seq_done));
    // Address gaps after ranks 13, 16 and 18 leave holes in the table
    function automatic logic [15:0] cw(input int k);
        cw = 16'hFE06 + 16'(2 * k) + (k >= 14 ? 16'h2 : 16'h0)
            + (k >= 17 ? 16'h2 : 16'h0) + (k >= 19 ? 16'h2 : 16'h0);
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic pulse(input logic [22:0] v, input logic [1:0] x);
        @(negedge mclk);
        r = v;
        sx = x;
        @(negedge mclk);
        r = 23'h0;
        sx = 2'h0;
    endtask
    task automatic grant(input int k);
        int i;
        for (i = 0; i < 40 && gv !== 1'b1; i++) @(negedge mclk);
        if (i == 40) begin fail_count++; results; end
        `CHK("rank", 5'(k), rank)
        `CHK("addr", cw(k), addr)
        `CHK("kind", kind[2*k+:2], gk)
        `CHK("vector hold", 1'b1, vh)
        for (i = 0; i < 40 && gv !== 1'b0; i++) @(negedge mclk);
        if (i == 40) begin fail_count++; results; end
    endtask
    task automatic one_by_one;
        for (int k = 0; k < 23; k++) begin
            pulse(23'h1 << k, 2'h0);
            grant(k);
        end
        pulse(23'h0, 2'h1);
        grant(14);
        pulse(23'h0, 2'h2);
        grant(17);
        `CHK("vector idle", 1'b0, vh)
    endtask
    task automatic all_at_once;
        gap = 4'h1;
        mask = 23'h000001;
        en = 23'h7FFFFD;
        pulse(23'h7FFFFF, 2'h0);
        for (int k = 2; k < 23; k++) grant(k);
        repeat (4) @(negedge mclk);
        `CHK("masked grant", 1'b0, gv)
        `CHK("held pending", 2'h3, pend[1:0])
        mask = 23'h0;
        grant(0);
        en = 23'h7FFFFF;
        grant(1);
        gap = 4'h3;
    endtask
    initial begin
        for (int k = 0; k < 23; k++) kind[2*k+:2] = 2'(k % 4);
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        one_by_one;
        all_at_once;
        results;
    end
endmodule
`default_nettype wire
